// ---- logic/pae_regs.vh ----
// Register map, field layout, reset values and timing constants of the alarm evaluator
`ifndef PAE_REGS_VH
`define PAE_REGS_VH

// Values are signed fixed point, 16 bits with 8 fraction bits
`define PAE_VAL_W 16
`define PAE_FRAC_ONE 16'h0100
`define PAE_FRAC_HALF 16'h0080
`define PAE_ZERO 16'h0000

// Address: [5:3] alarm_instance_select (1..6, 0 = global page), [2:0] register
`define PAE_ADDR_W 6
`define PAE_ALARM_INSTANCE_SELECT_HI 5
`define PAE_ALARM_INSTANCE_SELECT_LO 3
`define PAE_REG_HI 2
`define PAE_REG_LO 0
`define PAE_GLOBAL_PAGE 3'h0
`define PAE_ALARM_INSTANCE_SELECT_FIRST 3'h1
`define PAE_ALARM_INSTANCE_SELECT_LAST 3'h6

// Registers of each alarm_parameter_group page
`define PAE_REG_CFG 3'h0
`define PAE_REG_TRIP 3'h1
`define PAE_REG_HYST 3'h2
`define PAE_REG_DEV 3'h3
`define PAE_REG_RATE 3'h4
`define PAE_REG_STAT 3'h5
// Registers of the global page
`define PAE_REG_CONFIRM 3'h0
`define PAE_REG_INPUT 3'h1

// Configuration register fields
`define PAE_CFG_TYPE_HI 3
`define PAE_CFG_TYPE_LO 0
`define PAE_CFG_LATCH_HI 5
`define PAE_CFG_LATCH_LO 4
`define PAE_CFG_UNIT_HI 7
`define PAE_CFG_UNIT_LO 6
`define PAE_CFG_INHIBIT 8
`define PAE_CFG_W 9
`define PAE_CFG_RESET 9'h000

// Alarm types
`define PAE_T_OFF 4'h0
`define PAE_T_ABS_HI 4'h1
`define PAE_T_ABS_LO 4'h2
`define PAE_T_DEV_HI 4'h3
`define PAE_T_DEV_LO 4'h4
`define PAE_T_DEV_BAND 4'h5
`define PAE_T_RATE_UP 4'h6
`define PAE_T_RATE_DN 4'h7
`define PAE_T_DIG_HI 4'h8
`define PAE_T_DIG_LO 4'h9

// Latching modes
`define PAE_L_NONE 2'h0
`define PAE_L_AUTO 2'h1
`define PAE_L_MANUAL 2'h2
`define PAE_L_TRIGGER 2'h3

// Rate period units
`define PAE_U_SEC 2'h0
`define PAE_U_MIN 2'h1
`define PAE_U_HOUR 2'h2

// Status codes
`define PAE_S_OFF 2'h0
`define PAE_S_ACT_ACKED 2'h1
`define PAE_S_CLEARED_UNACK 2'h2
`define PAE_S_ACT_UNACK 2'h3

// Timebase
`define PAE_CLK_PERIOD_NS 100
`define PAE_SECOND_NS 1000000000
`define PAE_SEC_PER_MIN 6'h3b
`define PAE_MIN_PER_HOUR 6'h3b
`define PAE_TB_W 30

`endif

// ---- logic/pae_alarm_evaluator.v ----
// Six-instance process alarm evaluator with register port
//
// Added by the designer: the strobed register port and the placing of the registers.
`include "pae_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module pae_alarm_evaluator #(
    parameter N_ALARM_INSTANCE_SELECT = 6,
    parameter TICKS_PER_SEC = `PAE_SECOND_NS / `PAE_CLK_PERIOD_NS
) (
    input wire clk,
    input wire rstn,
    input wire in_valid,
    input wire [`PAE_VAL_W-1:0] in_value,
    input wire [`PAE_VAL_W-1:0] ref_value,
    input wire [`PAE_ADDR_W-1:0] reg_addr,
    input wire [`PAE_VAL_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`PAE_VAL_W-1:0] reg_rdata,
    output reg [N_ALARM_INSTANCE_SELECT-1:0] alarm_out
);

    localparam VW = `PAE_VAL_W;
    localparam [`PAE_TB_W-1:0] TB_LAST = TICKS_PER_SEC - 1;

    // Per-instance configuration, indexed by alarm_instance_select
    reg [`PAE_CFG_W-1:0] cfg [1:N_ALARM_INSTANCE_SELECT];
    reg [VW-1:0] trip_level [1:N_ALARM_INSTANCE_SELECT];
    reg [VW-1:0] hyst [1:N_ALARM_INSTANCE_SELECT];
    reg [VW-1:0] deviation [1:N_ALARM_INSTANCE_SELECT];
    reg [VW-1:0] rate_amount [1:N_ALARM_INSTANCE_SELECT];

    reg [VW-1:0] cur_value;
    reg [`PAE_TB_W-1:0] tb_count;
    reg [5:0] sec_count;
    reg [5:0] min_count;
    reg tick_sec;
    reg tick_min;
    reg tick_hour;

    wire [2:0] wr_alarm_instance_select = reg_addr[`PAE_ALARM_INSTANCE_SELECT_HI:`PAE_ALARM_INSTANCE_SELECT_LO];
    wire [2:0] wr_reg = reg_addr[`PAE_REG_HI:`PAE_REG_LO];
    wire alarm_instance_select_hit = (wr_alarm_instance_select >= `PAE_ALARM_INSTANCE_SELECT_FIRST) && (wr_alarm_instance_select <= `PAE_ALARM_INSTANCE_SELECT_LAST);
    wire confirm_wr = reg_wr && (wr_alarm_instance_select == `PAE_GLOBAL_PAGE) && (wr_reg == `PAE_REG_CONFIRM);
    wire alarm_instance_select_wr = reg_wr && alarm_instance_select_hit;

    // One write enable per writable register of the addressed instance page; the status register has none
    wire wr_cfg = alarm_instance_select_wr && (wr_reg == `PAE_REG_CFG);
    wire wr_trip = alarm_instance_select_wr && (wr_reg == `PAE_REG_TRIP);
    wire wr_hyst = alarm_instance_select_wr && (wr_reg == `PAE_REG_HYST);
    wire wr_dev = alarm_instance_select_wr && (wr_reg == `PAE_REG_DEV);
    wire wr_rate = alarm_instance_select_wr && (wr_reg == `PAE_REG_RATE);

    wire [2*N_ALARM_INSTANCE_SELECT-1:0] status_flat;
    wire [2*N_ALARM_INSTANCE_SELECT-1:0] next_status_flat;

    reg [VW-1:0] next_rdata;

    integer k;

    // Configuration writes
    always @(posedge clk) begin
        if (!rstn) begin
            for (k = 1; k <= N_ALARM_INSTANCE_SELECT; k = k + 1) begin
                cfg[k] <= `PAE_CFG_RESET;
                trip_level[k] <= `PAE_FRAC_ONE;
                hyst[k] <= `PAE_ZERO;
                deviation[k] <= `PAE_ZERO;
                rate_amount[k] <= `PAE_ZERO;
            end
        end else begin
            if (wr_cfg)
                cfg[wr_alarm_instance_select] <= reg_wdata[`PAE_CFG_W-1:0];
            if (wr_trip)
                trip_level[wr_alarm_instance_select] <= reg_wdata;
            if (wr_hyst)
                hyst[wr_alarm_instance_select] <= reg_wdata;
            if (wr_dev)
                deviation[wr_alarm_instance_select] <= reg_wdata;
            if (wr_rate)
                rate_amount[wr_alarm_instance_select] <= reg_wdata;
        end
    end

    // Last strobed process value, read back on the global page; the reference
    // is used only in the evaluation cycle, so it is not kept
    always @(posedge clk) begin
        if (!rstn) begin
            cur_value <= `PAE_ZERO;
        end else if (in_valid) begin
            cur_value <= in_value;
        end
    end

    // Second, minute and hour ticks for the rate alarms; each is one cycle long
    wire sec_wrap = (tb_count == TB_LAST);
    wire min_wrap = sec_wrap && (sec_count == `PAE_SEC_PER_MIN);
    wire hour_wrap = min_wrap && (min_count == `PAE_MIN_PER_HOUR);

    always @(posedge clk) begin
        if (!rstn) begin
            tb_count <= {`PAE_TB_W{1'b0}};
            tick_sec <= 1'b0;
        end else if (sec_wrap) begin
            tb_count <= {`PAE_TB_W{1'b0}};
            tick_sec <= 1'b1;
        end else begin
            tb_count <= tb_count + {{(`PAE_TB_W-1){1'b0}}, 1'b1};
            tick_sec <= 1'b0;
        end
    end

    // Minutes are counted in seconds
    always @(posedge clk) begin
        if (!rstn) begin
            sec_count <= 6'h00;
            tick_min <= 1'b0;
        end else if (min_wrap) begin
            sec_count <= 6'h00;
            tick_min <= 1'b1;
        end else begin
            if (sec_wrap)
                sec_count <= sec_count + 6'h01;
            tick_min <= 1'b0;
        end
    end

    // Hours are counted in minutes
    always @(posedge clk) begin
        if (!rstn) begin
            min_count <= 6'h00;
            tick_hour <= 1'b0;
        end else if (hour_wrap) begin
            min_count <= 6'h00;
            tick_hour <= 1'b1;
        end else begin
            if (min_wrap)
                min_count <= min_count + 6'h01;
            tick_hour <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 1; g <= N_ALARM_INSTANCE_SELECT; g = g + 1) begin : alarm_instance_select
            wire [3:0] a_type = cfg[g][`PAE_CFG_TYPE_HI:`PAE_CFG_TYPE_LO];
            wire [1:0] latch = cfg[g][`PAE_CFG_LATCH_HI:`PAE_CFG_LATCH_LO];
            wire [1:0] unit = cfg[g][`PAE_CFG_UNIT_HI:`PAE_CFG_UNIT_LO];
            wire forced_off = cfg[g][`PAE_CFG_INHIBIT] || (a_type == `PAE_T_OFF);

            reg [1:0] status;
            reg src;
            reg confirm_pend;
            reg rate_cond;
            reg [VW-1:0] sample;

            // Signed arithmetic one bit wider so nothing wraps
            wire signed [VW:0] x = {in_value[VW-1], in_value};
            wire signed [VW:0] r = {ref_value[VW-1], ref_value};
            wire signed [VW:0] t = {trip_level[g][VW-1], trip_level[g]};
            wire signed [VW:0] h = {hyst[g][VW-1], hyst[g]};
            wire signed [VW:0] d = {deviation[g][VW-1], deviation[g]};
            wire signed [VW:0] ra = {rate_amount[g][VW-1], rate_amount[g]};
            wire signed [VW:0] cv = {cur_value[VW-1], cur_value};
            wire signed [VW:0] sv = {sample[VW-1], sample};
            wire signed [VW:0] half = {1'b0, `PAE_FRAC_HALF};
            wire signed [VW:0] diff = x - r;
            wire signed [VW:0] delta = cv - sv;
            wire signed [VW:0] hi_rel = t - h;
            wire signed [VW:0] lo_rel = t + h;
            // Magnitude of the deviation for the band type
            wire signed [VW:0] mag = diff[VW] ? -diff : diff;

            reg unit_tick;
            // Unit code three never ticks, which freezes a rate alarm where it stands
            always @* begin
                case (unit)
                    `PAE_U_SEC: unit_tick = tick_sec;
                    `PAE_U_MIN: unit_tick = tick_min;
                    `PAE_U_HOUR: unit_tick = tick_hour;
                    default: unit_tick = 1'b0;
                endcase
            end

            reg cond;
            always @* begin
                case (a_type)
                    `PAE_T_ABS_HI: cond = src ? (x >= hi_rel) : (x > t);
                    `PAE_T_ABS_LO: cond = src ? (x <= lo_rel) : (x < t);
                    `PAE_T_DEV_HI: cond = (diff >= d);
                    `PAE_T_DEV_LO: cond = (-diff >= d);
                    `PAE_T_DEV_BAND: cond = (mag >= d);
                    `PAE_T_RATE_UP: cond = rate_cond;
                    `PAE_T_RATE_DN: cond = rate_cond;
                    `PAE_T_DIG_HI: cond = (x >= half);
                    `PAE_T_DIG_LO: cond = (x < half);
                    default: cond = 1'b0;
                endcase
            end

            // Only an alarm already showing can be confirmed, so a stale confirm
            // never pre-acknowledges a later alarm
            wire ack_ok = confirm_pend && (status != `PAE_S_OFF);

            reg [1:0] next_status;
            always @* begin
                next_status = `PAE_S_OFF;
                case (latch)
                    `PAE_L_AUTO: begin
                        if (cond) begin
                            if ((status == `PAE_S_ACT_ACKED) ||
                                ((status == `PAE_S_ACT_UNACK) && ack_ok))
                                next_status = `PAE_S_ACT_ACKED;
                            else
                                next_status = `PAE_S_ACT_UNACK;
                        end else if ((status == `PAE_S_CLEARED_UNACK) ||
                                     (status == `PAE_S_ACT_UNACK)) begin
                            next_status = ack_ok ? `PAE_S_OFF : `PAE_S_CLEARED_UNACK;
                        end
                    end
                    `PAE_L_MANUAL: begin
                        if (cond) begin
                            next_status = `PAE_S_ACT_UNACK;
                        end else if (status == `PAE_S_CLEARED_UNACK) begin
                            next_status = ack_ok ? `PAE_S_OFF : `PAE_S_CLEARED_UNACK;
                        end else if (status != `PAE_S_OFF) begin
                            next_status = `PAE_S_CLEARED_UNACK;
                        end
                    end
                    default: begin
                        if (cond)
                            next_status = ((status == `PAE_S_ACT_ACKED) || ack_ok) ?
                                          `PAE_S_ACT_ACKED : `PAE_S_ACT_UNACK;
                    end
                endcase
            end

            // Status and the hysteresis side change only on a strobe, or clear at once while the instance is inhibited or off
            always @(posedge clk) begin
                if (!rstn) begin
                    status <= `PAE_S_OFF;
                    src <= 1'b0;
                end else if (forced_off) begin
                    status <= `PAE_S_OFF;
                    src <= 1'b0;
                end else if (in_valid) begin
                    status <= next_status;
                    src <= cond;
                end
            end

            // A confirm written in the evaluation cycle survives to the next one;
            // the set wins over its consumption
            always @(posedge clk) begin
                if (!rstn) begin
                    confirm_pend <= 1'b0;
                end else if (forced_off) begin
                    confirm_pend <= 1'b0;
                end else if (confirm_wr && reg_wdata[g-1]) begin
                    confirm_pend <= 1'b1;
                end else if (in_valid) begin
                    confirm_pend <= 1'b0;
                end
            end

            // Rate: change since the previous tick of the chosen unit
            always @(posedge clk) begin
                if (!rstn) begin
                    sample <= `PAE_ZERO;
                end else if (unit_tick) begin
                    sample <= cur_value;
                end
            end

            // The verdict holds from one tick to the next, so a slow ramp
            // between strobes is still judged over the whole period
            always @(posedge clk) begin
                if (!rstn) begin
                    rate_cond <= 1'b0;
                end else if (unit_tick) begin
                    case (a_type)
                        `PAE_T_RATE_UP: rate_cond <= (delta > ra);
                        `PAE_T_RATE_DN: rate_cond <= (-delta > ra);
                        default: rate_cond <= 1'b0;
                    endcase
                end
            end

            // What status will hold after this edge, for the output register
            reg [1:0] status_after;
            always @* begin
                if (forced_off)
                    status_after = `PAE_S_OFF;
                else if (in_valid)
                    status_after = next_status;
                else
                    status_after = status;
            end

            assign status_flat[2*g-1:2*g-2] = status;
            assign next_status_flat[2*g-1:2*g-2] = status_after;
        end
    endgenerate

    // Outputs follow the status in the same edge
    always @(posedge clk) begin
        if (!rstn) begin
            alarm_out <= {N_ALARM_INSTANCE_SELECT{1'b0}};
        end else begin
            for (k = 0; k < N_ALARM_INSTANCE_SELECT; k = k + 1) begin
                alarm_out[k] <= (next_status_flat[2*k+1 -: 2] != `PAE_S_OFF);
            end
        end
    end

    // Read mux; a strobe that hits no register returns zero
    always @* begin
        next_rdata = `PAE_ZERO;
        if (reg_rd && alarm_instance_select_hit) begin
            case (wr_reg)
                `PAE_REG_CFG: next_rdata = {{(VW-`PAE_CFG_W){1'b0}}, cfg[wr_alarm_instance_select]};
                `PAE_REG_TRIP: next_rdata = trip_level[wr_alarm_instance_select];
                `PAE_REG_HYST: next_rdata = hyst[wr_alarm_instance_select];
                `PAE_REG_DEV: next_rdata = deviation[wr_alarm_instance_select];
                `PAE_REG_RATE: next_rdata = rate_amount[wr_alarm_instance_select];
                `PAE_REG_STAT: next_rdata = {{(VW-2){1'b0}},
                                             status_flat[2*wr_alarm_instance_select-1 -: 2]};
                default: next_rdata = `PAE_ZERO;
            endcase
        end else if (reg_rd && (wr_alarm_instance_select == `PAE_GLOBAL_PAGE)) begin
            case (wr_reg)
                `PAE_REG_CONFIRM: next_rdata = {{(VW-N_ALARM_INSTANCE_SELECT){1'b0}}, alarm_out};
                `PAE_REG_INPUT: next_rdata = cur_value;
                default: next_rdata = `PAE_ZERO;
            endcase
        end
    end

    // Read data appear in the cycle after the strobe only
    always @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= `PAE_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// ---- sim/pae_alarm_evaluator_props.sv ----
// Port-level assertions for the alarm evaluator
`include "pae_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module pae_alarm_evaluator_props #(
    parameter N_ALARM_INSTANCE_SELECT = 6,
    parameter TICKS_PER_SEC = 10
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic [15:0] in_value,
    input wire logic [15:0] ref_value,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [N_ALARM_INSTANCE_SELECT-1:0] alarm_out
);
    logic [15:0] last_in;
    wire logic [2:0] pg = reg_addr[5:3];
    wire logic alarm_instance_select_pg = pg != 3'h0 && pg != 3'h7;
    // Shadow of the last strobed value, so readback is judged without the body
    always @(posedge clk) begin
        if (!rstn)
            last_in <= 16'h0000;
        else if (in_valid)
            last_in <= in_value;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    rise_strobe_a: assert property ((alarm_out & ~$past(alarm_out)) != 0 |-> $past(in_valid))
        else $error("alarm rose without input strobe");
    out_readback_a: assert property (reg_rd && reg_addr == 6'h00 && !in_valid
        |=> reg_rdata == 16'($past(alarm_out)))
        else $error("global read differs from alarm outputs");
    in_readback_a: assert property (reg_rd && reg_addr == 6'h01 |=> reg_rdata == $past(last_in))
        else $error("input readback wrong");
    status_out_a: assert property (reg_rd && reg_addr[2:0] == 3'h5 && alarm_instance_select_pg && !in_valid
        |=> reg_rdata[15:2] == 14'h0 && (reg_rdata != 0) == $past(alarm_out[pg - 3'h1]))
        else $error("status and alarm output disagree");
    unmapped_zero_a: assert property (reg_rd && reg_addr[2:0] > 3'h5 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    reset_clear_a: assert property (disable iff (1'b0) !rstn |=> alarm_out == 0 && reg_rdata == 0)
        else $error("outputs not cleared by reset");
    inhibit_off_a: assert property (reg_wr && reg_addr[2:0] == 3'h0 && alarm_instance_select_pg
        && (reg_wdata[3:0] == 4'h0 || reg_wdata[8])
        |-> ##2 !alarm_out[$past(pg, 2) - 3'h1])
        else $error("disabled or inhibited alarm still on");
endmodule
bind pae_alarm_evaluator pae_alarm_evaluator_props #(.N_ALARM_INSTANCE_SELECT(N_ALARM_INSTANCE_SELECT), .TICKS_PER_SEC(TICKS_PER_SEC))
    props_u (.clk(clk), .rstn(rstn), .in_valid(in_valid), .in_value(in_value),
    .ref_value(ref_value), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm_out(alarm_out));
`default_nettype wire

// ---- sim/pae_source_model.sv ----
// Process measurement source with a one-cycle valid strobe
`timescale 1ns/100ps
`default_nettype none
module pae_source_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req,
    input wire logic [15:0] req_value,
    input wire logic [15:0] req_ref,
    output logic in_valid,
    output logic [15:0] in_value,
    output logic [15:0] ref_value
);
    // Off-strobe the values toggle, so a block sampling outside the strobe is caught
    always @(posedge clk) begin
        if (!rstn) begin
            in_valid <= 1'b0;
            in_value <= 16'h0000;
            ref_value <= 16'h0000;
        end else if (req) begin
            in_valid <= 1'b1;
            in_value <= req_value;
            ref_value <= req_ref;
        end else begin
            in_valid <= 1'b0;
            in_value <= ~in_value;
            ref_value <= ~ref_value;
        end
    end
endmodule
`default_nettype wire

// ---- sim/pae_alarm_evaluator_tb.sv ----
// Self-checking bench for the six-instance alarm evaluator
`include "pae_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module pae_alarm_evaluator_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic req = 1'b0;
    logic [15:0] req_value = 16'h0000;
    logic in_valid;
    logic [15:0] in_value;
    logic [15:0] ref_value;
    logic [5:0] reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [5:0] alarm_out;
    int n_fail = 0;
    int total_checks = 0;
    logic [15:0] tcfg [17] = '{16'h1, 16'h1, 16'h1, 16'h3, 16'h3, 16'h4, 16'h4, 16'h5, 16'h5,
        16'h5, 16'h38, 16'h38, 16'h9, 16'h9, 16'h9, 16'h109, 16'h0};
    logic [15:0] tin [17] = '{16'h101, 16'h100, 16'hff, 16'h120, 16'h11f, 16'he0, 16'he1,
        16'he0, 16'h120, 16'h110, 16'h80, 16'h7f, 16'h7f, 16'h80, 16'h0, 16'h0, 16'h0};
    logic [1:0] tex [17] = '{3, 3, 0, 3, 0, 3, 0, 3, 3, 0, 3, 0, 3, 0, 3, 0, 0};

    pae_alarm_evaluator #(.N_ALARM_INSTANCE_SELECT(6), .TICKS_PER_SEC(10)) dut_u (.clk(clk), .rstn(rstn),
        .in_valid(in_valid), .in_value(in_value), .ref_value(ref_value), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .alarm_out(alarm_out));
    // Reference stays at 1.0 for the deviation cases
    pae_source_model src_u (.clk(clk), .rstn(rstn), .req(req), .req_value(req_value),
        .req_ref(`PAE_FRAC_ONE), .in_valid(in_valid), .in_value(in_value),
        .ref_value(ref_value));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        total_checks++;
        if (reg_rdata !== exp) begin
            n_fail++;
            $display("unexpected at %0t: addr %h read %h not %h", $time, a, reg_rdata, exp);
        end
    endtask

    // Looks one step after the edge, once the output register has settled
    task automatic chk_out(input logic [5:0] exp);
        #1;
        total_checks++;
        if (alarm_out !== exp) begin
            n_fail++;
            $display("unexpected at %0t: alarm_out %h not %h", $time, alarm_out, exp);
        end
    endtask

    // Ends on the edge that evaluates, so status is settled on return
    task automatic smp(input logic [15:0] v);
        @(posedge clk);
        req <= 1'b1;
        req_value <= v;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reset_values;
        rd(6'h09, `PAE_FRAC_ONE);
        rd(6'h0a, `PAE_ZERO);
        wr(6'h0d, 16'h0003);
        rd(6'h0d, 16'h0000);
        rd(6'h0e, 16'h0000);
        rd(6'h36, 16'h0000);
    endtask

    task automatic abs_high_auto;
        wr(6'h0a, 16'h0040);
        wr(6'h08, 16'h0011);
        smp(16'h0100);
        rd(6'h0d, 16'h0000);
        smp(16'h0200);
        chk_out(6'h01);
        rd(6'h0d, 16'h0003);
        rd(6'h00, 16'h0001);
        rd(6'h01, 16'h0200);
        wr(6'h00, 16'h0001);
        smp(16'h0200);
        rd(6'h0d, 16'h0001);
        smp(16'h00c0);
        rd(6'h0d, 16'h0001);
        smp(16'h00bf);
        rd(6'h0d, 16'h0000);
        smp(16'h0200);
        smp(16'h0000);
        rd(6'h0d, 16'h0002);
        wr(6'h00, 16'h0001);
        smp(16'h0000);
        rd(6'h0d, 16'h0000);
    endtask

    task automatic abs_low_plain;
        wr(6'h12, 16'h0010);
        wr(6'h10, 16'h0002);
        smp(16'h0080);
        rd(6'h15, 16'h0003);
        smp(16'h0110);
        rd(6'h15, 16'h0003);
        smp(16'h0111);
        rd(6'h15, 16'h0000);
    endtask

    task automatic manual_latch;
        wr(6'h18, 16'h0028);
        smp(16'h0080);
        rd(6'h1d, 16'h0003);
        wr(6'h00, 16'h0004);
        smp(16'h0080);
        rd(6'h1d, 16'h0003);
        smp(16'h007f);
        rd(6'h1d, 16'h0002);
        smp(16'h007f);
        rd(6'h1d, 16'h0002);
        wr(6'h00, 16'h0004);
        smp(16'h007f);
        rd(6'h1d, 16'h0000);
    endtask

    task automatic type_table;
        wr(6'h23, 16'h0020);
        for (int i = 0; i < 17; i++) begin
            wr(6'h20, tcfg[i]);
            smp(tin[i]);
            rd(6'h25, {14'h0, tex[i]});
        end
    endtask

    // Steps of 0x40 every three cycles against a tick every ten cycles
    task automatic rate_types;
        wr(6'h2c, 16'h0010);
        wr(6'h34, 16'h0010);
        wr(6'h28, 16'h0006);
        wr(6'h30, 16'h0007);
        for (int i = 1; i <= 8; i++)
            smp(16'(i * 64));
        rd(6'h2d, 16'h0003);
        rd(6'h35, 16'h0000);
        for (int i = 7; i >= 0; i--)
            smp(16'(i * 64));
        rd(6'h35, 16'h0003);
        rd(6'h2d, 16'h0000);
        repeat (25) @(posedge clk);
        smp(16'h0000);
        rd(6'h35, 16'h0000);
        // Minute unit: strobes 601 or 603 edges apart see exactly one minute tick between them
        wr(6'h30, 16'h0047);
        smp(16'h0200);
        repeat (598) @(posedge clk);
        smp(16'h0000);
        repeat (598) @(posedge clk);
        smp(16'h0000);
        rd(6'h35, 16'h0003);
        repeat (598) @(posedge clk);
        smp(16'h0000);
        rd(6'h35, 16'h0000);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        reset_values;
        abs_high_auto;
        abs_low_plain;
        manual_latch;
        type_table;
        rate_types;
        summarize;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("unexpected at %0t: run did not end", $time);
        summarize;
    end
endmodule
`default_nettype wire
